//--- inc/syscall_pkg.sv
package syscall_pkg;

  // ***************************************
  // Register map
  // ***************************************
  localparam logic [3:0] ADR_ARG = 4'h0;
  localparam logic [3:0] ADR_REQ = 4'h4;
  localparam logic [3:0] ADR_CFG = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hC;
  localparam int REQ_FLAG_BIT = 31;
  localparam int CFG_PROT_OK_BIT = 0;
  localparam int CFG_IMO48_BIT = 1;
  localparam int CFG_HF_IMO_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [31:0] ARG_RESET = 32'h0000_0000;
  localparam logic [31:0] REQ_RESET = 32'h0000_0000;

  // ***************************************
  // Opcodes and keys
  // ***************************************
  localparam logic [15:0] OP_WRITE_ROW = 16'h0007;
  localparam logic [15:0] OP_PROGRAM_ROW = 16'h0008;
  localparam logic [15:0] OP_RESUME = 16'h0009;
  localparam logic [7:0] KEY_FIRST = 8'hB6;
  localparam logic [7:0] SECOND_KEY_WRITE_ROW = 8'hDA;
  localparam logic [7:0] SECOND_KEY_PROGRAM_ROW = 8'hDB;
  localparam logic [7:0] SECOND_KEY_RESUME = 8'hDC;
  localparam logic [15:0] ROW_COUNT = 16'h0200;

  // ***************************************
  // Status codes
  // ***************************************
  localparam logic [3:0] STATUS_OK_NIBBLE = 4'hA;
  localparam logic [7:0] STATUS_FAIL_BYTE = 8'hF0;
  localparam logic [7:0] FAIL_PROTECTION = 8'h01;
  localparam logic [7:0] FAIL_LATCH = 8'h03;
  localparam logic [7:0] FAIL_ADDRESS = 8'h04;
  localparam logic [7:0] FAIL_ROW_PROT = 8'h05;
  localparam logic [7:0] FAIL_RESUME_DONE = 8'h07;
  localparam logic [7:0] FAIL_PENDING = 8'h08;
  localparam logic [7:0] FAIL_IN_PROGRESS = 8'h09;
  localparam logic [7:0] FAIL_CHECKSUM = 8'h0A;
  localparam logic [7:0] FAIL_OPCODE = 8'h0B;
  localparam logic [7:0] FAIL_KEY = 8'h0C;
  localparam logic [7:0] FAIL_START_END = 8'h0E;
  localparam logic [7:0] FAIL_CLOCK = 8'h12;

  // ***************************************
  // Phases and states
  // ***************************************
  localparam logic [1:0] WRITE_ROW_EXTRA = 2'h2;
  localparam logic [1:0] PROGRAM_ROW_EXTRA = 2'h0;
  localparam logic [1:0] LEFT_ONE = 2'h1;

  typedef enum logic [1:0] {
    PH_PREPROG = 2'h0,
    PH_ERASE = 2'h1,
    PH_PROGRAM = 2'h2
  } phase_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FETCH = 6'h02,
    ST_WAIT = 6'h04,
    ST_CHECK = 6'h08,
    ST_LAUNCH = 6'h10,
    ST_FINISH = 6'h20
  } fsm_type;

  typedef struct packed {
    logic start;
    phase_type phase;
    logic [15:0] row;
  } fpc_cmd_type;

  typedef struct packed {
    fsm_type fsm;
    logic [31:0] arg;
    logic [31:0] req;
    logic [2:0] cfg;
    logic [31:0] params;
    logic pending;
    logic busy;
    logic irq;
    logic [1:0] left;
    logic fail;
    logic [7:0] code;
    fpc_cmd_type cmd;
    logic mem_req;
    logic ack;
    logic [31:0] rdat;
  } core_state_type;

endpackage

//--- rtl/syscall_status_word.sv
`timescale 1ns/1ps
module syscall_status_word (
  // Outcome
  input wire logic fail_in,
  input wire logic [7:0] code_in,
  // Word
  output logic [31:0] status_out
);

  // ***************************************
  // Status formatting
  // ***************************************
  always_comb begin
    if (fail_in) begin
      status_out = {syscall_pkg::STATUS_FAIL_BYTE, 16'h0000, code_in};
    end else begin
      status_out = {syscall_pkg::STATUS_OK_NIBBLE, 28'h000_0000};
    end
  end

endmodule

//--- rtl/nonblocking_flash_syscall.sv
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - First and second keys must match opcode, else fail with code 0x0C.
// - Program row is one phase: one controller interrupt, one resume finishes.
// - While operation pending, any defined call except resume fails with code 0x08.
// - Every call ends by overwriting argument word with a status.
// - Success places 0xA in top nibble, zeros below.
// - Failure status is 0xF0, zeros, then failure code byte.
// - Call not permitted by protection mode fails with code 0x01.
// - Page latch not valid for the call fails with code 0x03.
// - Row beyond available memory fails with code 0x04.
// - Protected row fails with code 0x05.
// - Resume with nothing outstanding fails with code 0x07.
// - Resume before phase finished fails with code 0x09.
// - Undefined opcode fails with code 0x0B.
// - Write row or program row needs 48 MHz oscillator driving clock, else code 0x12.
// - Write row runs pre-program, erase, program, interrupting after each.
module nonblocking_flash_syscall (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Parameter block reader
  output logic mem_req_out,
  output logic [31:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  // Flash program controller
  output logic phase_start_out,
  output logic [1:0] phase_sel_out,
  output logic [15:0] row_out,
  output logic fpc_irq_out,
  input wire logic phase_done_in,
  input wire logic row_protected_in,
  input wire logic latch_loaded_in
);

  syscall_pkg::core_state_type state_r;
  syscall_pkg::core_state_type state_nxt;
  logic [31:0] status_word;
  logic [15:0] opcode;
  logic [7:0] key_one;
  logic [7:0] key_two;
  logic [7:0] key_two_expected;
  logic defined_op;
  logic start_op;
  logic wb_hit;
  logic call_running;
  logic keys_ok;
  logic prot_ok;
  logic clock_ok;
  logic row_ok;
  logic phase_ready;
  logic more_phases;

  // ***************************************
  // Byte lane merge
  // ***************************************
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word, input logic [31:0] new_word,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ***************************************
  // Status formatting
  // ***************************************
  syscall_status_word u_status (
    .fail_in(state_r.fail),
    .code_in(state_r.code),
    .status_out(status_word)
  );

  // ***************************************
  // Request decode
  // ***************************************
  always_comb begin
    opcode = state_r.req[15:0];
    key_one = state_r.params[7:0];
    key_two = state_r.params[15:8];
    start_op = (opcode == syscall_pkg::OP_WRITE_ROW) || (opcode == syscall_pkg::OP_PROGRAM_ROW);
    defined_op = start_op || (opcode == syscall_pkg::OP_RESUME);
    unique case (opcode)
      syscall_pkg::OP_WRITE_ROW: begin
        key_two_expected = syscall_pkg::SECOND_KEY_WRITE_ROW;
      end
      syscall_pkg::OP_PROGRAM_ROW: begin
        key_two_expected = syscall_pkg::SECOND_KEY_PROGRAM_ROW;
      end
      default: begin
        key_two_expected = syscall_pkg::SECOND_KEY_RESUME;
      end
    endcase
  end

  assign wb_hit = wb_cyc_in && wb_stb_in && !state_r.ack;

  // ***************************************
  // Call checks
  // ***************************************
  always_comb begin
    call_running = (state_r.fsm != syscall_pkg::ST_IDLE);
    keys_ok = (key_one == syscall_pkg::KEY_FIRST) && (key_two == key_two_expected);
    prot_ok = state_r.cfg[syscall_pkg::CFG_PROT_OK_BIT];
    clock_ok = state_r.cfg[syscall_pkg::CFG_IMO48_BIT] && state_r.cfg[syscall_pkg::CFG_HF_IMO_BIT];
    row_ok = (state_r.cmd.row < syscall_pkg::ROW_COUNT);
    phase_ready = !state_r.busy && state_r.irq;
    more_phases = (state_r.left != syscall_pkg::PROGRAM_ROW_EXTRA);
  end

  // ***************************************
  // Next state
  // ***************************************
  always_comb begin
    state_nxt = state_r;
    state_nxt.cmd.start = 1'b0;
    state_nxt.ack = wb_hit;

    // Register reads
    if (wb_hit && !wb_we_in) begin
      unique case (wb_adr_in)
        syscall_pkg::ADR_ARG: begin
          state_nxt.rdat = state_r.arg;
        end
        syscall_pkg::ADR_REQ: begin
          state_nxt.rdat = state_r.req;
        end
        syscall_pkg::ADR_CFG: begin
          state_nxt.rdat = {29'h0000_0000, state_r.cfg};
        end
        syscall_pkg::ADR_STAT: begin
          state_nxt.rdat = {24'h00_0000, call_running, 1'b0, state_r.left,
                            1'b0, state_r.irq, state_r.busy, state_r.pending};
        end
        default: begin
          state_nxt.rdat = 32'h0000_0000;
        end
      endcase
    end

    // Register writes; argument and request frozen while a call runs
    if (wb_hit && wb_we_in) begin
      unique case (wb_adr_in)
        syscall_pkg::ADR_ARG: begin
          if (!call_running) begin
            state_nxt.arg = merge_bytes(state_r.arg, wb_dat_in, wb_sel_in);
          end
        end
        syscall_pkg::ADR_REQ: begin
          if (!call_running) begin
            state_nxt.req = merge_bytes(state_r.req, wb_dat_in, wb_sel_in);
          end
        end
        syscall_pkg::ADR_CFG: begin
          if (wb_sel_in[0]) begin
            state_nxt.cfg = wb_dat_in[2:0];
          end
        end
        default: begin
        end
      endcase
    end

    // Phase completion raises the controller interrupt
    if (phase_done_in && state_r.busy) begin
      state_nxt.busy = 1'b0;
      state_nxt.irq = 1'b1;
    end

    // Call sequencing
    unique case (state_r.fsm)
      syscall_pkg::ST_IDLE: begin
        if (state_r.req[syscall_pkg::REQ_FLAG_BIT]) begin
          state_nxt.fsm = syscall_pkg::ST_FETCH;
        end
      end
      syscall_pkg::ST_FETCH: begin
        state_nxt.mem_req = 1'b1;
        state_nxt.fsm = syscall_pkg::ST_WAIT;
      end
      syscall_pkg::ST_WAIT: begin
        if (mem_ack_in) begin
          state_nxt.mem_req = 1'b0;
          state_nxt.params = mem_rdata_in;
          if (!state_r.pending) begin
            state_nxt.cmd.row = mem_rdata_in[31:16];
          end
          state_nxt.fsm = syscall_pkg::ST_CHECK;
        end
      end
      syscall_pkg::ST_CHECK: begin
        state_nxt.fail = 1'b1;
        state_nxt.fsm = syscall_pkg::ST_FINISH;
        if (!defined_op) begin
          state_nxt.code = syscall_pkg::FAIL_OPCODE;
        end else if (state_r.pending && opcode != syscall_pkg::OP_RESUME) begin
          state_nxt.code = syscall_pkg::FAIL_PENDING;
        end else if (!keys_ok) begin
          state_nxt.code = syscall_pkg::FAIL_KEY;
        end else if (start_op) begin
          if (!prot_ok) begin
            state_nxt.code = syscall_pkg::FAIL_PROTECTION;
          end else if (!clock_ok) begin
            state_nxt.code = syscall_pkg::FAIL_CLOCK;
          end else if (!row_ok) begin
            state_nxt.code = syscall_pkg::FAIL_ADDRESS;
          end else if (row_protected_in) begin
            state_nxt.code = syscall_pkg::FAIL_ROW_PROT;
          end else if (!latch_loaded_in) begin
            state_nxt.code = syscall_pkg::FAIL_LATCH;
          end else begin
            state_nxt.fail = 1'b0;
            state_nxt.pending = 1'b1;
            state_nxt.fsm = syscall_pkg::ST_LAUNCH;
            if (opcode == syscall_pkg::OP_WRITE_ROW) begin
              state_nxt.left = syscall_pkg::WRITE_ROW_EXTRA;
              state_nxt.cmd.phase = syscall_pkg::PH_PREPROG;
            end else begin
              state_nxt.left = syscall_pkg::PROGRAM_ROW_EXTRA;
              state_nxt.cmd.phase = syscall_pkg::PH_PROGRAM;
            end
          end
        end else if (!state_r.pending) begin
          state_nxt.code = syscall_pkg::FAIL_RESUME_DONE;
        end else if (!phase_ready) begin
          state_nxt.code = syscall_pkg::FAIL_IN_PROGRESS;
        end else begin
          state_nxt.fail = 1'b0;
          state_nxt.irq = 1'b0;
          if (more_phases) begin
            state_nxt.left = state_r.left - syscall_pkg::LEFT_ONE;
            state_nxt.cmd.phase = (state_r.left == syscall_pkg::WRITE_ROW_EXTRA) ?
                                  syscall_pkg::PH_ERASE : syscall_pkg::PH_PROGRAM;
            state_nxt.fsm = syscall_pkg::ST_LAUNCH;
          end else begin
            state_nxt.pending = 1'b0;
          end
        end
      end
      syscall_pkg::ST_LAUNCH: begin
        state_nxt.cmd.start = 1'b1;
        state_nxt.busy = 1'b1;
        state_nxt.fsm = syscall_pkg::ST_FINISH;
      end
      syscall_pkg::ST_FINISH: begin
        state_nxt.arg = status_word;
        state_nxt.req[syscall_pkg::REQ_FLAG_BIT] = 1'b0;
        state_nxt.fsm = syscall_pkg::ST_IDLE;
      end
      default: begin
        state_nxt.fsm = syscall_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************
  // State register
  // ***************************************
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_r <= '0;
      state_r.fsm <= syscall_pkg::ST_IDLE;
      state_r.arg <= syscall_pkg::ARG_RESET;
      state_r.req <= syscall_pkg::REQ_RESET;
      state_r.cfg <= syscall_pkg::CFG_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************
  // Outputs
  // ***************************************
  assign wb_dat_out = state_r.rdat;
  assign wb_ack_out = state_r.ack;
  assign mem_req_out = state_r.mem_req;
  assign mem_addr_out = state_r.arg;
  assign phase_start_out = state_r.cmd.start;
  assign phase_sel_out = state_r.cmd.phase;
  assign row_out = state_r.cmd.row;
  assign fpc_irq_out = state_r.irq;

endmodule

//--- verification/nonblocking_flash_syscall_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module nonblocking_flash_syscall_sva (
  // Clock, reset and bus
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Far side
  input wire logic mem_req_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic mem_ack_in,
  input wire logic phase_start_out,
  input wire logic [1:0] phase_sel_out,
  input wire logic [15:0] row_out,
  input wire logic fpc_irq_out,
  input wire logic phase_done_in
);
  logic unmapped;
  assign unmapped = !(wb_adr_in inside {4'h0, 4'h4, 4'h8, 4'hC});
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("Bus access not acknowledged");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("Ack longer than one cycle");
  a_unmapped_zero: assert property (wb_ack_out && !wb_we_in && unmapped |-> wb_dat_out == 32'h0)
    else $error("Unmapped read not zero");
  a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("Parameter read dropped");
  a_start_pulse: assert property (phase_start_out |=> !phase_start_out) else $error("Start not a pulse");
  a_start_phase: assert property (phase_start_out |-> phase_sel_out <= 2'h2) else $error("Bad phase");
  a_start_row: assert property (phase_start_out |-> row_out < 16'h0200) else $error("Row out of range");
  a_irq_cause: assert property ($rose(fpc_irq_out) |-> $past(phase_done_in)) else $error("Irq no done");
  a_irq_row: assert property (fpc_irq_out |-> $stable(row_out)) else $error("Row moved while pending");
  c_start: cover property (phase_start_out && phase_sel_out == 2'h2);
  c_irq: cover property ($rose(fpc_irq_out));
  c_slow_mem: cover property (mem_req_out && !mem_ack_in ##1 mem_ack_in);
endmodule
bind nonblocking_flash_syscall nonblocking_flash_syscall_sva u_sva (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .mem_req_out(mem_req_out), .mem_addr_out(mem_addr_out),
  .mem_ack_in(mem_ack_in), .phase_start_out(phase_start_out), .phase_sel_out(phase_sel_out),
  .row_out(row_out), .fpc_irq_out(fpc_irq_out), .phase_done_in(phase_done_in));

//--- verification/flash_side_model.sv
`timescale 1ns/1ps
// ****************************************
// Parameter memory and flash controller model
// ****************************************
module flash_side_model #(
  parameter int DONE_DELAY = 150
) (
  // Clock, reset and bench control
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic slow_in,
  input wire logic [15:0] prot_row_in,
  // Parameter block port
  input wire logic mem_req_in,
  input wire logic [31:0] mem_addr_in,
  output logic mem_ack_out,
  output logic [31:0] mem_rdata_out,
  // Controller port
  input wire logic phase_start_in,
  input wire logic [15:0] row_in,
  output logic phase_done_out,
  output logic row_protected_out
);
  logic [31:0] sram [0:3];
  logic [7:0] wait_r;
  int busy_r;
  assign row_protected_out = (row_in == prot_row_in);
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 32'h0;
      wait_r <= 8'h0;
      busy_r <= 0;
      phase_done_out <= 1'b0;
    end else begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      phase_done_out <= 1'b0;
      if (mem_req_in && !mem_ack_out) begin
        if (wait_r == (slow_in ? 8'h4 : 8'h0)) begin
          mem_ack_out <= 1'b1;
          mem_rdata_out <= sram[mem_addr_in[3:2]];
          wait_r <= 8'h0;
        end else begin
          wait_r <= wait_r + 8'h1;
        end
      end
      if (phase_start_in) begin
        busy_r <= DONE_DELAY;
      end else if (busy_r == 1) begin
        phase_done_out <= 1'b1;
        busy_r <= 0;
      end else if (busy_r != 0) begin
        busy_r <= busy_r - 1;
      end
    end
  end
endmodule

//--- verification/nonblocking_flash_syscall_test.sv
`timescale 1ns/1ps
// ****************************************
// Testbench
// ****************************************
module nonblocking_flash_syscall_test;
  typedef struct packed {logic [2:0] cfg; logic latch; logic [31:0] prm; logic [15:0] op; logic [31:0] exp;} case_type;
  logic clk, nrst, cyc, stb, we, ack, mem_req, mem_ack, pstart, irq, pdone, rprot, latch, slow;
  logic [3:0] adr;
  logic [31:0] wdat, rdat, mem_addr, mem_rdata, st;
  logic [1:0] psel;
  logic [15:0] row;
  logic [1:0] ph_q [$];
  logic [1:0] ph_exp [4];
  case_type rows [11];
  int miscompares, comparisons, cycles, n;
  nonblocking_flash_syscall u_nonblocking_flash_syscall (.ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .mem_req_out(mem_req), .mem_addr_out(mem_addr), .mem_ack_in(mem_ack),
    .mem_rdata_in(mem_rdata), .phase_start_out(pstart), .phase_sel_out(psel), .row_out(row), .fpc_irq_out(irq),
    .phase_done_in(pdone), .row_protected_in(rprot), .latch_loaded_in(latch));
  flash_side_model u_model (.clk_in(clk), .nrst_in(nrst), .slow_in(slow), .prot_row_in(16'h0033),
    .mem_req_in(mem_req), .mem_addr_in(mem_addr), .mem_ack_out(mem_ack), .mem_rdata_out(mem_rdata),
    .phase_start_in(pstart), .row_in(row), .phase_done_out(pdone), .row_protected_out(rprot));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (pstart === 1'b1) ph_q.push_back(psel);
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("ERROR %0t: timeout", $time);
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic call(input logic [31:0] prm, input logic [15:0] op, output logic [31:0] res);
    logic [31:0] q;
    u_model.sram[0] = prm;
    wb(1'b1, syscall_pkg::ADR_ARG, 32'h2000_0000, q);
    wb(1'b1, syscall_pkg::ADR_REQ, {16'h8000, op}, q);
    q = 32'h8000_0000;
    while (q[31] !== 1'b0) begin
      wb(1'b0, syscall_pkg::ADR_REQ, 32'h0, q);
    end
    wb(1'b0, syscall_pkg::ADR_ARG, 32'h0, res);
  endtask
  task automatic wait_irq;
    for (int k = 0; k < 400 && irq !== 1'b1; k++) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    {nrst, cyc, stb, we, latch, slow} = 6'h0;
    adr = 4'h0;
    wdat = 32'h0;
    ph_exp = '{2'h2, 2'h0, 2'h1, 2'h2};
    rows = '{{3'h7, 1'b1, 32'h0005_DBB6, 16'h0005, 32'hF000_000B}, {3'h7, 1'b1, 32'h0005_DBB6, 16'h000A, 32'hF000_000B},
      {3'h7, 1'b1, 32'h0005_DAB6, 16'h0008, 32'hF000_000C}, {3'h7, 1'b1, 32'h0005_DBB5, 16'h0008, 32'hF000_000C},
      {3'h7, 1'b1, 32'h0000_DCB6, 16'h0009, 32'hF000_0007}, {3'h7, 1'b1, 32'h0200_DBB6, 16'h0008, 32'hF000_0004},
      {3'h6, 1'b1, 32'h0005_DBB6, 16'h0008, 32'hF000_0001}, {3'h5, 1'b1, 32'h0005_DBB6, 16'h0008, 32'hF000_0012},
      {3'h3, 1'b1, 32'h0005_DAB6, 16'h0007, 32'hF000_0012}, {3'h7, 1'b1, 32'h0033_DBB6, 16'h0008, 32'hF000_0005},
      {3'h7, 1'b0, 32'h0005_DBB6, 16'h0008, 32'hF000_0003}};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (ph_exp[i]) begin
      wb(1'b0, 4'(i * 4), 32'h0, st);
      chk(st, 32'h0);
    end
    wb(1'b1, 4'h2, 32'hFFFF_FFFF, st);
    wb(1'b0, 4'h2, 32'h0, st);
    chk(st, 32'h0);
    $display("Reset and map test done");
    foreach (rows[i]) begin
      wb(1'b1, syscall_pkg::ADR_CFG, {29'h0, rows[i].cfg}, st);
      latch <= rows[i].latch;
      call(rows[i].prm, rows[i].op, st);
      chk(st, rows[i].exp);
    end
    $display("Table test done");
    latch <= 1'b1;
    slow <= 1'b1;
    call(32'h01FF_DBB6, 16'h0008, st);
    chk(st, 32'hA000_0000);
    chk({16'h0, row}, 32'h0000_01FF);
    call(32'h0005_DAB6, 16'h0007, st);
    chk(st, 32'hF000_0008);
    call(32'h0000_DCB6, 16'h0009, st);
    chk(st, 32'hF000_0009);
    wait_irq();
    call(32'hFFFF_DCB6, 16'h0009, st);
    chk(st, 32'hA000_0000);
    chk({31'h0, irq}, 32'h0);
    $display("Program row test done");
    slow <= 1'b0;
    call(32'h0100_DAB6, 16'h0007, st);
    chk(st, 32'hA000_0000);
    for (n = 0; n < 3; n++) begin
      wait_irq();
      call(32'h0000_DCB6, 16'h0009, st);
      chk(st, 32'hA000_0000);
    end
    call(32'h0000_DCB6, 16'h0009, st);
    chk(st, 32'hF000_0007);
    chk(ph_q.size(), 32'h4);
    foreach (ph_exp[i]) chk({30'h0, ph_q[i]}, {30'h0, ph_exp[i]});
    $display("Write row test done");
    report_and_stop();
  end
endmodule
